// >>> hdl/ibtc_ctrl.sv
`timescale 1ns/1ns
module ibtc_ctrl (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // terminal pins
    input wire logic supply_24v_present,
    input wire logic mains_present,
    input wire logic run_clockwise_input,
    input wire logic run_counterclockwise_input,
    input wire logic speed_select_input,
    input wire logic thermostat_option_switch,
    // switches and setpoints
    input wire logic [3:0] second_speed_switch,
    input wire logic [3:0] ramp_time_switch,
    input wire logic [7:0] pot_speed_setpoint,
    input wire logic [3:0] special_function,
    input wire logic bus_mode,
    // motor state from the speed controller
    input wire logic [7:0] motor_freq_hz,
    input wire logic down_ramp,
    input wire logic phase_loss,
    // control word port
    input wire logic [15:0] cmd_wdata,
    input wire logic cmd_we,
    // outputs
    output logic brake_release,
    output logic brake_relay_contact,
    output logic output_stage_enable,
    output logic run_cw,
    output logic run_ccw,
    output logic [1:0] status_lamp,
    output logic [7:0] setpoint_hz,
    output logic [7:0] ramp_tenths,
    output logic [7:0] ramp_ref_hz,
    output logic [7:0] min_freq_hz,
    output logic [15:0] premag_ms,
    output logic [7:0] fault_code,
    output logic model_protection_on,
    output logic fault_reset_pulse,
    output logic ready
);
    logic [5:0] pins;
    logic supply_s, mains_s, cw_s, ccw_s, sel_s, th_opt_s;
    logic [15:0] drive_command_word;
    logic [7:0] fault;
    logic rapid_stop_latched;
    logic next_release;
    logic hoist, rapid_start, th_fn, low_min;
    ibtc_pkg::ibtc_state_t state;
    ibtc_pkg::ibtc_state_t next_state;

    ibtc_sync #(.W(6)) u_sync (
        .mclk(mclk),
        .rst(rst),
        .din({supply_24v_present, mains_present, run_clockwise_input,
              run_counterclockwise_input, speed_select_input, thermostat_option_switch}),
        .dout(pins)
    );
    assign {supply_s, mains_s, cw_s, ccw_s, sel_s, th_opt_s} = pins;

    assign hoist = (special_function == ibtc_pkg::SF_HOIST) ||
                   (special_function == ibtc_pkg::SF_RAPID) ||
                   (special_function == ibtc_pkg::SF_RAPID_TH);
    assign rapid_start = (special_function == ibtc_pkg::SF_RAPID) ||
                         (special_function == ibtc_pkg::SF_RAPID_TH);
    assign th_fn = special_function == ibtc_pkg::SF_RAPID_TH;
    assign low_min = (special_function == ibtc_pkg::SF_ZERO_MIN) ||
                     (special_function == ibtc_pkg::SF_LOW_TORQUE);

    // write-only control word
    always_ff @(posedge mclk) begin
        if (rst) begin
            drive_command_word <= ibtc_pkg::CMD_RESET_VAL;
        end else if (cmd_we) begin
            drive_command_word <= cmd_wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            fault_reset_pulse <= 1'b0;
        end else begin
            fault_reset_pulse <= cmd_we && cmd_wdata[ibtc_pkg::BIT_RESET] &&
                                 !drive_command_word[ibtc_pkg::BIT_RESET];
        end
    end

    always_comb begin
        if (!supply_s) begin
            next_state = ibtc_pkg::IBTC_OFF;
        end else if (!mains_s) begin
            next_state = ibtc_pkg::IBTC_STOP_NO_MAINS;
        end else if (cw_s ^ ccw_s) begin
            next_state = ibtc_pkg::IBTC_RUN;
        end else begin
            next_state = ibtc_pkg::IBTC_STOP;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state <= ibtc_pkg::IBTC_OFF;
            run_cw <= 1'b0;
            run_ccw <= 1'b0;
            status_lamp <= ibtc_pkg::IBTC_LED_OFF;
        end else begin
            state <= next_state;
            run_cw <= (next_state == ibtc_pkg::IBTC_RUN) && cw_s;
            run_ccw <= (next_state == ibtc_pkg::IBTC_RUN) && ccw_s;
            case (next_state)
                ibtc_pkg::IBTC_OFF: status_lamp <= ibtc_pkg::IBTC_LED_OFF;
                ibtc_pkg::IBTC_STOP_NO_MAINS: status_lamp <= ibtc_pkg::IBTC_LED_FLASH_YELLOW;
                ibtc_pkg::IBTC_STOP: status_lamp <= ibtc_pkg::IBTC_LED_YELLOW;
                ibtc_pkg::IBTC_RUN: status_lamp <= ibtc_pkg::IBTC_LED_GREEN;
                default: status_lamp <= ibtc_pkg::IBTC_LED_OFF;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            setpoint_hz <= '0;
            ramp_tenths <= '0;
            ramp_ref_hz <= ibtc_pkg::RAMP_REF_HZ;
            min_freq_hz <= ibtc_pkg::MIN_FREQ_STD_HZ;
            premag_ms <= ibtc_pkg::PREMAG_STD_MS;
        end else begin
            if (!sel_s) begin
                setpoint_hz <= pot_speed_setpoint;
            end else if (second_speed_switch > 4'hA) begin
                setpoint_hz <= ibtc_pkg::SPEED2_HZ[10];
            end else begin
                setpoint_hz <= ibtc_pkg::SPEED2_HZ[second_speed_switch];
            end
            ramp_tenths <= (ramp_time_switch > 4'hA) ? ibtc_pkg::RAMP_TENTHS[10]
                                                     : ibtc_pkg::RAMP_TENTHS[ramp_time_switch];
            ramp_ref_hz <= ibtc_pkg::RAMP_REF_HZ;
            min_freq_hz <= low_min ? ibtc_pkg::MIN_FREQ_ZERO_HZ : ibtc_pkg::MIN_FREQ_STD_HZ;
            premag_ms <= rapid_start ? ibtc_pkg::PREMAG_ZERO_MS : ibtc_pkg::PREMAG_STD_MS;
        end
    end

    // rapid stop: latched until the down ramp ends so the stage stays blocked
    always_ff @(posedge mclk) begin
        if (rst) begin
            rapid_stop_latched <= 1'b0;
        end else if (!down_ramp || state != ibtc_pkg::IBTC_RUN) begin
            rapid_stop_latched <= 1'b0;
        end else if (hoist && bus_mode && drive_command_word[ibtc_pkg::BIT_BRAKE]) begin
            rapid_stop_latched <= 1'b1;
        end else if (motor_freq_hz < ibtc_pkg::STOP_FREQ_HZ) begin
            rapid_stop_latched <= 1'b1;
        end
    end

    // shared by brake output and, in hoist modes, relay so both switch on the same edge
    assign next_release = (state == ibtc_pkg::IBTC_RUN) && !rapid_stop_latched &&
                          (fault == ibtc_pkg::FAULT_NONE);

    always_ff @(posedge mclk) begin
        if (rst) begin
            brake_release <= 1'b0;
            output_stage_enable <= 1'b0;
        end else begin
            brake_release <= next_release;
            output_stage_enable <= (state == ibtc_pkg::IBTC_RUN) && !rapid_stop_latched &&
                                   (fault == ibtc_pkg::FAULT_NONE);
        end
    end

    // faults; set wins over the reset pulse
    always_ff @(posedge mclk) begin
        if (rst) begin
            fault <= ibtc_pkg::FAULT_NONE;
        end else if (th_fn && bus_mode && th_opt_s && !cw_s && !ccw_s && mains_s && supply_s) begin
            fault <= ibtc_pkg::FAULT_MOTOR_TEMP;
        end else if (phase_loss && special_function != ibtc_pkg::SF_NO_PHASE && supply_s) begin
            fault <= ibtc_pkg::FAULT_PHASE;
        end else if (fault_reset_pulse) begin
            fault <= ibtc_pkg::FAULT_NONE;
        end
    end
    assign fault_code = fault;

    always_ff @(posedge mclk) begin
        if (rst) begin
            model_protection_on <= 1'b1;
        end else begin
            model_protection_on <= !(th_fn && th_opt_s);
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            brake_relay_contact <= 1'b0;
            ready <= 1'b0;
        end else begin
            ready <= (state == ibtc_pkg::IBTC_RUN || state == ibtc_pkg::IBTC_STOP) &&
                     (fault == ibtc_pkg::FAULT_NONE);
            brake_relay_contact <= hoist ? next_release
                                         : ((state == ibtc_pkg::IBTC_RUN || state == ibtc_pkg::IBTC_STOP) &&
                                            (fault == ibtc_pkg::FAULT_NONE));
        end
    end
endmodule

// >>> hdl/ibtc_pkg.sv
// What this block does
// - bus hoist: bit 9 on down ramp brakes
// - below 3 Hz on down ramp brake
// - hoist: relay is brake output only
// - terminal mode ignores bit 9
// - brake signal 1 releases, 0 engages
// - function 11 skips phase-loss supervision
// - function 12 bus: thermostat fault 84 conditions
// - option switch off: motor-model protection
// - rapid start: zero pre-magnetization time
// - without 7, 9, 12 relay means ready
// - terminal inputs decode to run state, lamp
// - speed select picks pot or switch setpoint
// - ramp switch selects ramp time, 50 Hz
// - reduced torque permits 0 Hz minimum
package ibtc_pkg;
    localparam int CMD_W = 16;
    localparam int BIT_RESET = 6;
    localparam int BIT_BRAKE = 9;
    localparam logic [15:0] CMD_RESET_VAL = 16'h0000;
    localparam int FREQ_W = 8;
    localparam logic [7:0] STOP_FREQ_HZ = 8'h03;
    localparam logic [7:0] FAULT_MOTOR_TEMP = 8'h54;
    localparam logic [7:0] FAULT_PHASE = 8'h06;
    localparam logic [7:0] FAULT_NONE = 8'h00;
    localparam logic [3:0] SF_RAPID = 4'h7;
    localparam logic [3:0] SF_ZERO_MIN = 4'h8;
    localparam logic [3:0] SF_HOIST = 4'h9;
    localparam logic [3:0] SF_LOW_TORQUE = 4'hA;
    localparam logic [3:0] SF_NO_PHASE = 4'hB;
    localparam logic [3:0] SF_RAPID_TH = 4'hC;
    localparam logic [7:0] MIN_FREQ_STD_HZ = 8'h02;
    localparam logic [7:0] MIN_FREQ_ZERO_HZ = 8'h00;
    // pre-magnetization in ms
    localparam logic [15:0] PREMAG_STD_MS = 16'h0190;
    localparam logic [15:0] PREMAG_ZERO_MS = 16'h0000;
    // ramp times in 0.1 s units, positions 0..10
    localparam logic [7:0] RAMP_TENTHS [0:10] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h07,
        8'h0A, 8'h14, 8'h1E, 8'h32, 8'h46, 8'h64};
    localparam logic [7:0] RAMP_REF_HZ = 8'h32;
    localparam logic [7:0] SPEED2_HZ [0:10] = '{8'h05, 8'h07, 8'h0A, 8'h0F, 8'h14, 8'h19,
        8'h23, 8'h32, 8'h3C, 8'h46, 8'h64};
    typedef enum logic [2:0] {
        IBTC_LAMP_OFF = 3'h1,
        IBTC_LAMP_FLASH_YELLOW = 3'h2,
        IBTC_LAMP_YELLOW = 3'h4
    } ibtc_lamp_base_t;
    typedef enum logic [3:0] {
        IBTC_OFF = 4'h1,
        IBTC_STOP_NO_MAINS = 4'h2,
        IBTC_STOP = 4'h4,
        IBTC_RUN = 4'h8
    } ibtc_state_t;
    typedef enum logic [1:0] {
        IBTC_LED_OFF = 2'h0,
        IBTC_LED_FLASH_YELLOW = 2'h1,
        IBTC_LED_YELLOW = 2'h2,
        IBTC_LED_GREEN = 2'h3
    } ibtc_led_t;
endpackage

// >>> hdl/ibtc_sync.sv
`timescale 1ns/1ns
// three-stage synchroniser; change accepted when stages two and three agree
module ibtc_sync #(
    parameter int W = 1
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    always_ff @(posedge mclk) begin
        if (rst) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            dout <= '0;
        end else begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
            for (int i = 0; i < W; i++) begin
                if (s2[i] == s3[i]) begin
                    dout[i] <= s3[i];
                end
            end
        end
    end
endmodule

// >>> verif/ibtc_ctrl_properties.sv
`timescale 1ns/1ns
module ibtc_ctrl_properties (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // watched ports
    input wire logic [3:0] special_function,
    input wire logic bus_mode,
    input wire logic [7:0] motor_freq_hz,
    input wire logic down_ramp,
    input wire logic [15:0] cmd_wdata,
    input wire logic cmd_we,
    input wire logic brake_release,
    input wire logic brake_relay_contact,
    input wire logic output_stage_enable,
    input wire logic run_cw,
    input wire logic run_ccw,
    input wire logic [1:0] status_lamp,
    input wire logic [15:0] premag_ms,
    input wire logic [7:0] fault_code,
    input wire logic fault_reset_pulse,
    input wire logic ready
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (rst);
    logic last_b6;
    wire hoist = special_function inside {4'h7, 4'h9, 4'hC};
    wire run = run_cw || run_ccw;
    always_ff @(posedge mclk) last_b6 <= rst ? 1'b0 : (cmd_we ? cmd_wdata[6] : last_b6);
    chk_bit9_brake: assert property (bus_mode && hoist && down_ramp && run && cmd_we && cmd_wdata[9]
        ##1 down_ramp |-> ##1 !brake_release && !output_stage_enable) else $error("bit 9 no brake");
    chk_stop_freq: assert property (down_ramp && run && motor_freq_hz < 8'h03 ##1 down_ramp && run
        |-> ##1 !brake_release) else $error("stop freq no brake");
    chk_relay_brake: assert property (hoist && $past(hoist)
        |-> brake_relay_contact == brake_release) else $error("relay not brake");
    chk_relay_ready: assert property (!hoist && $past(!hoist)
        |-> brake_relay_contact == ready) else $error("relay not ready");
    chk_lamp_run: assert property ((status_lamp == 2'h3) == (run_cw ^ run_ccw))
        else $error("lamp vs run");
    chk_thermal_bus: assert property (!bus_mode && $past(!bus_mode)
        |-> !(fault_code == 8'h54 && $past(fault_code) != 8'h54)) else $error("thermal fault off bus");
    chk_premag_zero: assert property (special_function inside {4'h7, 4'hC} && $stable(special_function)
        |-> premag_ms == 16'h0000) else $error("premag not zero");
    chk_reset_pulse: assert property (cmd_we && cmd_wdata[6] && !last_b6
        |=> fault_reset_pulse ##1 !fault_reset_pulse) else $error("reset pulse");
endmodule
bind ibtc_ctrl ibtc_ctrl_properties u_props (.mclk(mclk), .rst(rst), .special_function(special_function),
    .bus_mode(bus_mode), .motor_freq_hz(motor_freq_hz), .down_ramp(down_ramp), .cmd_wdata(cmd_wdata),
    .cmd_we(cmd_we), .brake_release(brake_release), .brake_relay_contact(brake_relay_contact),
    .output_stage_enable(output_stage_enable), .run_cw(run_cw), .run_ccw(run_ccw), .status_lamp(status_lamp),
    .premag_ms(premag_ms), .fault_code(fault_code), .fault_reset_pulse(fault_reset_pulse), .ready(ready));

// >>> verif/ibtc_master.sv
`timescale 1ns/1ns
module ibtc_master (
    // clock
    input wire logic mclk,
    // control word port
    output logic [15:0] cmd_wdata,
    output logic cmd_we
);
    initial cmd_we = 1'b0;
    initial cmd_wdata = 16'h0000;
    task automatic write(input logic [15:0] w);
        @(posedge mclk);
        #1;
        cmd_wdata = w & 16'h0247;
        cmd_we = 1'b1;
        @(posedge mclk);
        #1;
        cmd_we = 1'b0;
        // stale word must not look valid
        cmd_wdata = ~cmd_wdata;
    endtask
endmodule

// >>> verif/inverter_brake_and_terminal_control_tb.sv
`timescale 1ns/1ns
module inverter_brake_and_terminal_control_tb;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic s24, mns, cw, ccw, sel, th, bus, dr, ph, we, brk, rly, ose, rcw, rccw, mp, rdy;
    logic [3:0] sw2, swr, sf;
    logic [7:0] pot, frq, sp, rt, rr, mf, fc;
    logic [1:0] lamp;
    logic [15:0] wd, pm;
    int miscompares = 0;
    int check_count = 0;
    always #50 mclk = ~mclk;
    ibtc_master M (.mclk(mclk), .cmd_wdata(wd), .cmd_we(we));
    ibtc_ctrl DUT (.mclk(mclk), .rst(rst), .supply_24v_present(s24), .mains_present(mns),
        .run_clockwise_input(cw), .run_counterclockwise_input(ccw), .speed_select_input(sel),
        .thermostat_option_switch(th), .second_speed_switch(sw2), .ramp_time_switch(swr),
        .pot_speed_setpoint(pot), .special_function(sf), .bus_mode(bus), .motor_freq_hz(frq),
        .down_ramp(dr), .phase_loss(ph), .cmd_wdata(wd), .cmd_we(we), .brake_release(brk),
        .brake_relay_contact(rly), .output_stage_enable(ose), .run_cw(rcw), .run_ccw(rccw),
        .status_lamp(lamp), .setpoint_hz(sp), .ramp_tenths(rt), .ramp_ref_hz(rr), .min_freq_hz(mf),
        .premag_ms(pm), .fault_code(fc), .model_protection_on(mp), .fault_reset_pulse(), .ready(rdy));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %0t got %0h want %0h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic t_terminal();
        logic [7:0] tab [6] = '{8'h70, 8'hB4, 8'hC8, 8'hEE, 8'hDD, 8'hF8};
        for (int i = 0; i < 6; i++) begin
            {s24, mns, cw, ccw} = tab[i][7:4];
            tick(6);
            chk({lamp, rcw, rccw}, tab[i][3:0]);
        end
    endtask
    task automatic t_speed();
        logic [7:0] hz [11] = '{8'h05, 8'h07, 8'h0A, 8'h0F, 8'h14, 8'h19, 8'h23, 8'h32, 8'h3C, 8'h46, 8'h64};
        logic [7:0] ds [11] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h07, 8'h0A, 8'h14, 8'h1E, 8'h32, 8'h46, 8'h64};
        {s24, mns, cw, ccw} = 4'hE;
        tick(6);
        chk(sp, 8'h2A);
        pot = 8'h37;
        tick(3);
        chk(sp, 8'h37);
        sel = 1'b1;
        for (int i = 0; i <= 10; i++) begin
            sw2 = i[3:0];
            swr = i[3:0];
            tick(6);
            chk({sp, rt, rr}, {hz[i], ds[i], 8'h32});
        end
    endtask
    task automatic t_brake();
        bus = 1'b1;
        sf = 4'h9;
        M.write(16'h0200);
        tick(3);
        chk({brk, ose, rly}, 3'h7);
        dr = 1'b1;
        M.write(16'h0200);
        tick(3);
        chk({brk, ose, rly}, 3'h0);
        dr = 1'b0;
        M.write(16'h0000);
        bus = 1'b0;
        dr = 1'b1;
        M.write(16'h0200);
        tick(3);
        chk(brk, 1'b1);
        frq = 8'h02;
        tick(3);
        chk(brk, 1'b0);
        dr = 1'b0;
        frq = 8'h14;
    endtask
    task automatic t_special();
        bus = 1'b1;
        sf = 4'h7;
        tick(3);
        chk(pm, 16'h0000);
        sf = 4'hA;
        tick(3);
        chk({mf, rly === rdy}, {8'h00, 1'b1});
        sf = 4'hB;
        ph = 1'b1;
        tick(6);
        chk(fc, 8'h00);
        sf = 4'h0;
        tick(6);
        chk({fc, pm, mf}, {8'h06, 16'h0190, 8'h02});
        ph = 1'b0;
        M.write(16'h0040);
        tick(3);
        chk(fc, 8'h00);
        M.write(16'h0000);
    endtask
    task automatic t_thermal();
        sf = 4'hC;
        {s24, mns, cw, ccw} = 4'hC;
        tick(6);
        chk({fc, mp}, {8'h00, 1'b1});
        th = 1'b1;
        tick(6);
        chk({fc, mp}, {8'h54, 1'b0});
        th = 1'b0;
        // the option pin needs the synchroniser delay to drop before a clear can win
        tick(6);
        M.write(16'h0040);
        tick(3);
        chk(fc, 8'h00);
    endtask
    initial begin
        {s24, mns, cw, ccw, sel, th, bus, dr, ph} = 9'h000;
        {sw2, swr, sf} = 12'h000;
        pot = 8'h2A;
        frq = 8'h14;
        tick(16);
        chk({rr, mf, pm, brk, fc, mp}, {8'h32, 8'h02, 16'h0190, 1'b0, 8'h00, 1'b1});
        rst = 1'b0;
        t_terminal();
        t_speed();
        t_brake();
        t_special();
        t_thermal();
        summarize();
    end
endmodule
